// ---- verilog/fbph_handler.v ----
// Fieldbus process word handler: control, speed, outputs, parameters, faults
// Functional notes
// - Speed word scale: 8191 equals synchronous speed, others proportional.
// - Speed words above 8191 accepted, but clamped to maximum reference.
// - Output word bits 8..12 select output a, b, relays a, b, c.
// - Output word bits 0..4 give the state, applied only where selected.
// - An output changes only if its source is assigned to fieldbus.
// - Parameter named by read selector returns in the fourth read word.
// - Change-number 999 is idle: no parameter write happens.
// - Scalar-to-vector change refused while a motor-model parameter is zero.
// - Disabled-only fault: change needs disabled drive, or setting conflict.
// - Nonexistent-parameter fault: unknown read/write number or protected write.
// - Out-of-range fault: content outside range, change not applied.
// - Not-permitted fault: unassigned function, unassigned output, read-only write.
// - Access faults clear on a correct action; unassigned function/output need control write.
// - Writing 999 clears faults except unassigned function/output ones.
// - Access faults only indicate; they never touch run or enable state.
// - Link interruption raises fieldbus-inactive fault and loss action.
// - Board-inactive fault: board missing, defective, or wrong standard.
// - Words laid out consecutively from address 00h, both directions.
// - Control bit executes only when its high-order select bit is 1.
// - Status low byte carries fault code; access faults are 24..27.
`timescale 1ns/1ps
`include "fbph_consts.vh"
module fbph_handler (
  input  wire        ref_clk,
  input  wire        rst,
  // Word writes from the fieldbus board
  input  wire        wr_strobe,
  input  wire [2:0]  wr_index,
  input  wire [15:0] wr_data,
  // Word reads to the fieldbus board
  input  wire [2:0]  rd_index,
  output reg  [15:0] rd_data_r,
  // Drive state feeding the read words and the change checks
  input  wire [7:0]  drive_state_hi,
  input  wire [7:0]  drive_fault_code,
  input  wire [15:0] motor_speed,
  input  wire [7:0]  digital_inputs,
  input  wire [15:0] torque_current,
  input  wire [15:0] motor_current,
  input  wire        drive_enabled,
  // Configuration
  input  wire [3:0]  fieldbus_standard_select,
  input  wire [2:0]  link_loss_behaviour,
  input  wire [4:0]  ctl_src_fieldbus,
  input  wire [4:0]  out_src_fieldbus,
  input  wire [15:0] max_speed_ref,
  input  wire [11:0] sync_speed_rpm,
  // Board and link pins
  input  wire        link_up,
  input  wire        board_present,
  input  wire        board_defective,
  input  wire [1:0]  board_standard,
  input  wire        panel_program_key,
  // Parameter store lookup for param_num_r
  output reg  [15:0] param_num_r,
  input  wire        param_exists,
  input  wire        param_protected,
  input  wire        param_read_only,
  input  wire        param_needs_disable,
  input  wire        param_conflict,
  input  wire        model_change_blocked,
  input  wire [15:0] param_min,
  input  wire [15:0] param_max,
  input  wire [15:0] param_value,
  output reg         param_wr_r,
  output reg  [15:0] param_wr_value_r,
  // Drive commands
  output reg  [4:0]  cmd_state_r,
  output reg         fault_reset_r,
  output reg         save_enable_r,
  output reg  [15:0] speed_ref_r,
  output reg  [11:0] speed_ref_rpm_r,
  output wire        digital_out_a,
  output wire        digital_out_b,
  output wire        relay_a,
  output wire        relay_b,
  output wire        relay_c,
  // Fault indications
  output wire [7:0]  fault_code,
  output reg         disabled_only_fault_r,
  output reg         nonexistent_parameter_fault_r,
  output reg         out_of_range_fault_r,
  output reg         not_permitted_fault_r,
  output reg         fieldbus_inactive_fault_r,
  output reg         board_inactive_fault_r,
  output reg         loss_action_r,
  output reg  [2:0]  loss_action_sel_r
);
  localparam CHK_IDLE = 2'h0;
  localparam CHK_READ = 2'h1;
  localparam CHK_WRT  = 2'h2;
  localparam CHK_BACK = 2'h3;

  function in_range;
    input [15:0] v;
    input [15:0] lo;
    input [15:0] hi;
    begin
      in_range = (v >= lo) && (v <= hi);
    end
  endfunction

  function [1:0] std_family;
    input [3:0] sel;
    begin
      case (sel)
        4'h1, 4'h2, 4'h3:        std_family = `FBPH_STD_PB;
        4'h4, 4'h5, 4'h6, 4'ha:  std_family = `FBPH_STD_DN;
        4'h7, 4'h8, 4'h9:        std_family = `FBPH_STD_EIP;
        default:                 std_family = `FBPH_STD_NONE;
      endcase
    end
  endfunction

  // Synchronised pins
  wire link_s;
  wire present_s;
  wire defect_s;
  wire key_s;
  wire std0_s;
  wire std1_s;

  fbph_sync u_sync_link (.ref_clk(ref_clk), .rst(rst), .d_in(link_up), .q_out(link_s));
  fbph_sync u_sync_pres (.ref_clk(ref_clk), .rst(rst), .d_in(board_present), .q_out(present_s));
  fbph_sync u_sync_def  (.ref_clk(ref_clk), .rst(rst), .d_in(board_defective), .q_out(defect_s));
  fbph_sync u_sync_key  (.ref_clk(ref_clk), .rst(rst), .d_in(panel_program_key), .q_out(key_s));
  fbph_sync u_sync_std0 (.ref_clk(ref_clk), .rst(rst), .d_in(board_standard[0]), .q_out(std0_s));
  fbph_sync u_sync_std1 (.ref_clk(ref_clk), .rst(rst), .d_in(board_standard[1]), .q_out(std1_s));

  // Write decode
  wire wr_ctrl   = wr_strobe && (wr_index == `FBPH_W_CTRL);
  wire wr_speed  = wr_strobe && (wr_index == `FBPH_W_SPEED);
  wire wr_outs   = wr_strobe && (wr_index == `FBPH_W_OUTS);
  wire wr_rdsel  = wr_strobe && (wr_index == `FBPH_W_RDSEL);
  wire wr_chgnum = wr_strobe && (wr_index == `FBPH_W_CHGNUM);
  wire wr_chgval = wr_strobe && (wr_index == `FBPH_W_CHGVAL);

  // Outputs under the output-control word
  wire [4:0] out_state;
  wire       out_unassigned;
  wire       out_accepted;

  fbph_out_ctl u_outs (
    .ref_clk      (ref_clk),
    .rst          (rst),
    .wr_en        (wr_outs),
    .wr_word      (wr_data),
    .src_fieldbus (out_src_fieldbus),
    .out_state_r  (out_state),
    .unassigned_r (out_unassigned),
    .accepted_r   (out_accepted)
  );

  assign digital_out_a = out_state[0];
  assign digital_out_b = out_state[1];
  assign relay_a       = out_state[2];
  assign relay_b       = out_state[3];
  assign relay_c       = out_state[4];

  // Logical control word
  wire [4:0] csel_w   = wr_data[`FBPH_CSEL_LSB +: `FBPH_CFN];
  wire [4:0] cval_w   = wr_data[`FBPH_CVAL_LSB +: `FBPH_CFN];
  wire       fn_bad_w = |(csel_w & ~ctl_src_fieldbus);
  reg        frst_prev_r;
  reg        fn_bad_r;
  reg        ctrl_ok_r;
  integer    k;

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cmd_state_r   <= 5'h00;
      fault_reset_r <= 1'b0;
      save_enable_r <= 1'b0;
      frst_prev_r   <= 1'b0;
      fn_bad_r      <= 1'b0;
      ctrl_ok_r     <= 1'b0;
    end else begin
      fault_reset_r <= 1'b0;
      fn_bad_r      <= wr_ctrl & fn_bad_w;
      ctrl_ok_r     <= wr_ctrl & ~fn_bad_w;
      if (wr_ctrl) begin
        for (k = 0; k < `FBPH_CFN; k = k + 1) begin
          if (csel_w[k] && ctl_src_fieldbus[k]) begin
            cmd_state_r[k] <= cval_w[k];
          end
        end
        if (wr_data[`FBPH_SAVE_SEL]) begin
          save_enable_r <= ~wr_data[`FBPH_SAVE_VAL];
        end
        if (wr_data[`FBPH_FRST_SEL]) begin
          frst_prev_r   <= wr_data[`FBPH_FRST_VAL];
          fault_reset_r <= wr_data[`FBPH_FRST_VAL] & ~frst_prev_r;
        end
      end
    end
  end

  // Speed reference, clamped and converted to rpm
  wire [15:0] spd_lim_w = (wr_data > max_speed_ref) ? max_speed_ref : wr_data;
  wire [27:0] spd_prod  = spd_lim_w * sync_speed_rpm;
  wire [27:0] spd_rpm   = spd_prod / {12'h000, `FBPH_SYNC_SPEED};

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      speed_ref_r     <= `FBPH_RST_WORD;
      speed_ref_rpm_r <= 12'h000;
    end else if (wr_speed) begin
      speed_ref_r     <= spd_lim_w;
      speed_ref_rpm_r <= spd_rpm[11:0];
    end
  end

  // Parameter read selector and change sequence
  reg [1:0]  chk_state_r;
  reg [15:0] rd_num_r;
  reg [15:0] chg_num_r;
  reg [15:0] chg_val_r;
  reg [15:0] param_rd_val_r;
  reg        idle_wr_r;
  reg        p_nopar_r;
  reg        p_disoly_r;
  reg        p_range_r;
  reg        p_ro_r;
  reg        p_ok_r;

  wire chg_active = (chg_num_r != `FBPH_IDLE_CODE);
  wire new_num    = wr_chgnum && (wr_data != `FBPH_IDLE_CODE);
  wire new_val    = wr_chgval && chg_active;

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      chk_state_r      <= CHK_IDLE;
      rd_num_r         <= `FBPH_RST_WORD;
      chg_num_r        <= `FBPH_IDLE_CODE;
      chg_val_r        <= `FBPH_RST_WORD;
      param_num_r      <= `FBPH_RST_WORD;
      param_rd_val_r   <= `FBPH_RST_WORD;
      param_wr_r       <= 1'b0;
      param_wr_value_r <= `FBPH_RST_WORD;
      idle_wr_r        <= 1'b0;
      p_nopar_r        <= 1'b0;
      p_disoly_r       <= 1'b0;
      p_range_r        <= 1'b0;
      p_ro_r           <= 1'b0;
      p_ok_r           <= 1'b0;
    end else begin
      param_wr_r <= 1'b0;
      p_nopar_r  <= 1'b0;
      p_disoly_r <= 1'b0;
      p_range_r  <= 1'b0;
      p_ro_r     <= 1'b0;
      p_ok_r     <= 1'b0;
      idle_wr_r  <= wr_chgnum && (wr_data == `FBPH_IDLE_CODE);
      if (wr_chgnum) begin
        chg_num_r <= wr_data;
      end
      if (wr_chgval) begin
        chg_val_r <= wr_data;
      end
      if (wr_rdsel) begin
        rd_num_r <= wr_data;
      end
      case (chk_state_r)
        CHK_IDLE: begin
          if (new_num || new_val) begin
            param_num_r <= new_num ? wr_data : chg_num_r;
            chk_state_r <= CHK_WRT;
          end else if (wr_rdsel) begin
            param_num_r <= wr_data;
            chk_state_r <= CHK_READ;
          end else if (rd_num_r != param_num_r) begin
            param_num_r <= rd_num_r;
            chk_state_r <= CHK_BACK;
          end else begin
            param_rd_val_r <= param_value;
          end
        end
        CHK_READ: begin
          chk_state_r <= CHK_IDLE;
          if (param_exists) begin
            param_rd_val_r <= param_value;
            p_ok_r         <= 1'b1;
          end else begin
            p_nopar_r <= 1'b1;
          end
        end
        CHK_WRT: begin
          chk_state_r <= CHK_IDLE;
          if (!param_exists || param_protected) begin
            p_nopar_r <= 1'b1;
          end else if (param_read_only) begin
            p_ro_r <= 1'b1;
          end else if ((param_needs_disable && drive_enabled) || param_conflict
                       || model_change_blocked) begin
            p_disoly_r <= 1'b1;
          end else if (!in_range(chg_val_r, param_min, param_max)) begin
            p_range_r <= 1'b1;
          end else if (chg_active) begin
            param_wr_r       <= 1'b1;
            param_wr_value_r <= chg_val_r;
            p_ok_r           <= 1'b1;
          end
        end
        // Background refresh is no action from the master, so it clears no fault
        CHK_BACK: begin
          chk_state_r <= CHK_IDLE;
          if (param_exists) begin
            param_rd_val_r <= param_value;
          end else begin
            p_nopar_r <= 1'b1;
          end
        end
        default: begin
          chk_state_r <= CHK_IDLE;
        end
      endcase
    end
  end

  // Access faults: status only, no path into the command outputs
  reg  perm_sticky_r;
  wire any_set   = p_nopar_r | p_disoly_r | p_range_r | p_ro_r | fn_bad_r | out_unassigned;
  wire soft_clr  = p_ok_r | out_accepted | ctrl_ok_r | idle_wr_r;

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      disabled_only_fault_r         <= 1'b0;
      nonexistent_parameter_fault_r <= 1'b0;
      out_of_range_fault_r          <= 1'b0;
      not_permitted_fault_r         <= 1'b0;
      perm_sticky_r                 <= 1'b0;
    end else if (any_set) begin
      disabled_only_fault_r         <= p_disoly_r;
      nonexistent_parameter_fault_r <= p_nopar_r;
      out_of_range_fault_r          <= p_range_r;
      not_permitted_fault_r         <= p_ro_r | fn_bad_r | out_unassigned;
      perm_sticky_r                 <= fn_bad_r | out_unassigned;
    end else if (ctrl_ok_r || (soft_clr && !perm_sticky_r)) begin
      disabled_only_fault_r         <= 1'b0;
      nonexistent_parameter_fault_r <= 1'b0;
      out_of_range_fault_r          <= 1'b0;
      not_permitted_fault_r         <= 1'b0;
      perm_sticky_r                 <= 1'b0;
    end
  end

  // Link and board supervision
  reg  link_prev_r;
  reg  key_prev_r;
  reg  [1:0] sync_fill_r;
  wire bus_on     = (fieldbus_standard_select != 4'h0);
  wire link_drop  = bus_on && link_prev_r && !link_s;
  wire key_press  = key_s && !key_prev_r;
  // Board pins are judged only once the synchronisers hold real samples
  wire board_bad  = sync_fill_r[1] && bus_on && (!present_s || defect_s ||
                    (std_family(fieldbus_standard_select) != {std1_s, std0_s}));

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      link_prev_r               <= 1'b0;
      key_prev_r                <= 1'b0;
      sync_fill_r               <= 2'h0;
      fieldbus_inactive_fault_r <= 1'b0;
      board_inactive_fault_r    <= 1'b0;
      loss_action_r             <= 1'b0;
      loss_action_sel_r         <= 3'h0;
    end else begin
      link_prev_r <= link_s;
      key_prev_r  <= key_s;
      sync_fill_r <= {sync_fill_r[0], 1'b1};
      if (link_drop) begin
        fieldbus_inactive_fault_r <= 1'b1;
      end else if (key_press) begin
        fieldbus_inactive_fault_r <= 1'b0;
      end
      if (board_bad) begin
        board_inactive_fault_r <= 1'b1;
      end else if (key_press) begin
        board_inactive_fault_r <= 1'b0;
      end
      loss_action_r     <= fieldbus_inactive_fault_r | board_inactive_fault_r;
      loss_action_sel_r <= link_loss_behaviour;
    end
  end

  // Status low byte and read words
  assign fault_code = board_inactive_fault_r        ? `FBPH_CODE_BOARD   :
                      fieldbus_inactive_fault_r     ? `FBPH_CODE_LINK    :
                      disabled_only_fault_r         ? `FBPH_CODE_DISOLY  :
                      nonexistent_parameter_fault_r ? `FBPH_CODE_NOPAR   :
                      out_of_range_fault_r          ? `FBPH_CODE_RANGE   :
                      not_permitted_fault_r         ? `FBPH_CODE_NOTPERM :
                      drive_fault_code;

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rd_data_r <= `FBPH_RST_WORD;
    end else begin
      case (rd_index)
        `FBPH_R_STATUS:  rd_data_r <= {drive_state_hi, fault_code};
        `FBPH_R_SPEED:   rd_data_r <= motor_speed;
        `FBPH_R_DIN:     rd_data_r <= {8'h00, digital_inputs};
        `FBPH_R_PARAM:   rd_data_r <= param_rd_val_r;
        `FBPH_R_TORQUE:  rd_data_r <= torque_current;
        `FBPH_R_CURRENT: rd_data_r <= motor_current;
        default:         rd_data_r <= `FBPH_RST_WORD;
      endcase
    end
  end
endmodule // fbph_handler

// ---- include/fbph_consts.vh ----
// Constants of the fieldbus process word handler
`ifndef FBPH_CONSTS_VH
`define FBPH_CONSTS_VH
// Word positions in the board memory, both directions from 00h
`define FBPH_BASE_ADDR     3'h0
`define FBPH_W_CTRL        3'h0
`define FBPH_W_SPEED       3'h1
`define FBPH_W_OUTS        3'h2
`define FBPH_W_RDSEL       3'h3
`define FBPH_W_CHGNUM      3'h4
`define FBPH_W_CHGVAL      3'h5
`define FBPH_R_STATUS      3'h0
`define FBPH_R_SPEED       3'h1
`define FBPH_R_DIN         3'h2
`define FBPH_R_PARAM       3'h3
`define FBPH_R_TORQUE      3'h4
`define FBPH_R_CURRENT     3'h5
// Speed scaling
`define FBPH_SYNC_SPEED    16'h1fff
// Idle code of the change-number word (999)
`define FBPH_IDLE_CODE     16'h03e7
// Output-control word fields
`define FBPH_OSEL_LSB      8
`define FBPH_OVAL_LSB      0
`define FBPH_NOUT          5
// Logical control fields
`define FBPH_CSEL_LSB      8
`define FBPH_CVAL_LSB      0
`define FBPH_CFN           5
`define FBPH_SAVE_SEL      13
`define FBPH_SAVE_VAL      5
`define FBPH_FRST_SEL      15
`define FBPH_FRST_VAL      7
// Fault codes
`define FBPH_CODE_NONE     8'h00
`define FBPH_CODE_DISOLY   8'h18
`define FBPH_CODE_NOPAR    8'h19
`define FBPH_CODE_RANGE    8'h1a
`define FBPH_CODE_NOTPERM  8'h1b
`define FBPH_CODE_LINK     8'h1d
`define FBPH_CODE_BOARD    8'h1e
// Standard families
`define FBPH_STD_NONE      2'h0
`define FBPH_STD_PB        2'h1
`define FBPH_STD_DN        2'h2
`define FBPH_STD_EIP       2'h3
// Reset values
`define FBPH_RST_OUTS      5'h00
`define FBPH_RST_WORD      16'h0000
`endif

// ---- verilog/fbph_sync.v ----
// Two-flop synchroniser for one level from outside the clock domain
`timescale 1ns/1ps
module fbph_sync (
  input  wire ref_clk,
  input  wire rst,
  input  wire d_in,
  output reg  q_out
);
  reg meta_r;

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      meta_r <= 1'b0;
      q_out  <= 1'b0;
    end else begin
      meta_r <= d_in;
      q_out  <= meta_r;
    end
  end
endmodule // fbph_sync

// ---- verilog/fbph_out_ctl.v ----
// Digital and relay outputs driven by the output-control word
`timescale 1ns/1ps
`include "fbph_consts.vh"
module fbph_out_ctl (
  input  wire       ref_clk,
  input  wire       rst,
  input  wire       wr_en,
  input  wire [15:0] wr_word,
  input  wire [4:0] src_fieldbus,
  output reg  [4:0] out_state_r,
  output reg        unassigned_r,
  output reg        accepted_r
);
  wire [4:0] sel_w = wr_word[`FBPH_OSEL_LSB +: `FBPH_NOUT];
  wire [4:0] val_w = wr_word[`FBPH_OVAL_LSB +: `FBPH_NOUT];
  wire [4:0] upd_w = sel_w & src_fieldbus;

  integer i;

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      out_state_r  <= `FBPH_RST_OUTS;
      unassigned_r <= 1'b0;
      accepted_r   <= 1'b0;
    end else begin
      unassigned_r <= wr_en & (|(sel_w & ~src_fieldbus));
      accepted_r   <= wr_en & ~(|(sel_w & ~src_fieldbus));
      if (wr_en) begin
        for (i = 0; i < `FBPH_NOUT; i = i + 1) begin
          if (upd_w[i]) begin
            out_state_r[i] <= val_w[i];
          end
        end
      end
    end
  end
endmodule // fbph_out_ctl

// ---- verif/fbph_handler_props.sv ----
// Checker on the handler ports
`timescale 1ns/1ps
module fbph_props (
  input wire        ref_clk,
  input wire        rst,
  input wire        wr_strobe,
  input wire [2:0]  wr_index,
  input wire [15:0] wr_data,
  input wire [2:0]  rd_index,
  input wire [15:0] rd_data_r,
  input wire [4:0]  out_src_fieldbus,
  input wire [15:0] max_speed_ref,
  input wire [15:0] speed_ref_r,
  input wire        digital_out_a,
  input wire        relay_c,
  input wire [7:0]  fault_code,
  input wire        param_wr_r,
  input wire [15:0] param_wr_value_r,
  input wire [15:0] param_max,
  input wire        param_read_only,
  input wire        board_inactive_fault_r
);
  wire ow = wr_strobe && wr_index == 3'h2;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_out_apply: assert property (
    ow && wr_data[8] && out_src_fieldbus[0] |=> digital_out_a == $past(wr_data[0]))
    else $error("output a not applied");
  a_out_unsel: assert property (
    ow && !wr_data[8] |=> $stable(digital_out_a)) else $error("unselected output moved");
  a_out_unowned: assert property (
    ow && !out_src_fieldbus[4] |=> $stable(relay_c)) else $error("unowned relay moved");
  a_idle_quiet: assert property (
    wr_strobe && wr_index == 3'h4 && wr_data == 16'h03e7 |=> !param_wr_r [*3])
    else $error("write while idle");
  a_range_keep: assert property (
    param_wr_r |-> param_wr_value_r <= param_max) else $error("out of range written");
  a_ro_keep: assert property (
    param_wr_r |-> !param_read_only) else $error("read-only written");
  a_speed_clamp: assert property (
    wr_strobe && wr_index == 3'h1 |=> speed_ref_r ==
      ($past(wr_data) > max_speed_ref ? max_speed_ref : $past(wr_data)))
    else $error("speed clamp wrong");
  a_board_code: assert property (
    board_inactive_fault_r |-> fault_code == 8'h1e) else $error("board code wrong");
  a_status_code: assert property (
    rd_index == 3'h0 |=> rd_data_r[7:0] == $past(fault_code)) else $error("status wrong");
  c_param_wr: cover property (param_wr_r);
  c_board: cover property (board_inactive_fault_r);
  c_unowned: cover property (ow && wr_data[12] && !out_src_fieldbus[4]);
endmodule // fbph_props

// ---- verif/fbph_param_store.sv ----
// Parameter store model behind the handler lookup port
`timescale 1ns/1ps
module fbph_param_store (
  input  wire        ref_clk,
  input  wire [15:0] param_num_r,
  input  wire        param_wr_r,
  input  wire [15:0] param_wr_value_r,
  output wire        param_exists,
  output wire        param_protected,
  output wire        param_read_only,
  output wire        param_needs_disable,
  output wire        param_conflict,
  output wire        model_change_blocked,
  output wire [15:0] param_min,
  output wire [15:0] param_max,
  output wire [15:0] param_value
);
  reg [15:0] store_r = 16'h0032;
  // 100 writable 0..1000, 101 read-only, 102 needs a stopped drive, 408 protected, 202 blocked
  assign param_exists = (param_num_r >= 16'h0064 && param_num_r <= 16'h0066) ||
                        param_protected || model_change_blocked;
  assign param_protected = param_num_r == 16'h0198;
  assign param_read_only = param_num_r == 16'h0065;
  assign param_needs_disable = param_num_r == 16'h0066;
  assign param_conflict = 1'b0;
  assign model_change_blocked = param_num_r == 16'h00ca;
  assign param_min = 16'h0000;
  assign param_max = 16'h03e8;
  assign param_value = store_r;
  always @(posedge ref_clk) begin
    if (param_wr_r && param_num_r == 16'h0064) begin
      store_r <= param_wr_value_r;
    end
  end
endmodule // fbph_param_store

// ---- verif/fbph_handler_tb_top.sv ----
// Bench of the fieldbus process word handler
`timescale 1ns/1ps
module fbph_handler_tb_top;
  reg         ref_clk, rst, wr_strobe, drive_enabled, link_up, board_present;
  reg         board_defective, panel_program_key;
  reg  [2:0]  wr_index, rd_index, link_loss_behaviour;
  reg  [15:0] wr_data, motor_speed, torque_current, motor_current, max_speed_ref;
  reg  [7:0]  drive_state_hi, drive_fault_code, digital_inputs;
  reg  [3:0]  fieldbus_standard_select;
  reg  [4:0]  ctl_src_fieldbus, out_src_fieldbus;
  reg  [11:0] sync_speed_rpm;
  reg  [1:0]  board_standard;
  wire        param_exists, param_protected, param_read_only, param_needs_disable;
  wire        param_conflict, model_change_blocked, param_wr_r, fault_reset_r;
  wire        save_enable_r, loss_action_r, digital_out_a, digital_out_b, relay_a;
  wire        relay_b, relay_c, disabled_only_fault_r, out_of_range_fault_r;
  wire        nonexistent_parameter_fault_r, not_permitted_fault_r;
  wire        fieldbus_inactive_fault_r, board_inactive_fault_r;
  wire [15:0] param_min, param_max, param_value, rd_data_r, param_num_r;
  wire [15:0] param_wr_value_r, speed_ref_r;
  wire [11:0] speed_ref_rpm_r;
  wire [4:0]  cmd_state_r;
  wire [7:0]  fault_code;
  wire [2:0]  loss_action_sel_r;
  integer     n_errors, tests_run, k;
  wire [4:0]  outs = {relay_c, relay_b, relay_a, digital_out_b, digital_out_a};
  wire [3:0]  flt = {disabled_only_fault_r, nonexistent_parameter_fault_r,
                     out_of_range_fault_r, not_permitted_fault_r};
  wire [63:0] pnum = {16'h00ca, 16'h0198, 16'h0066, 16'h0065};
  wire [15:0] pflt = {4'h8, 4'h4, 4'h8, 4'h1};
  wire [31:0] pcode = {8'h18, 8'h19, 8'h18, 8'h1b};

  fbph_handler uut (.*);
  fbph_param_store u_store (.*);

  initial begin
    ref_clk = 0;
    forever #25 ref_clk = ~ref_clk;
  end
  task cyc(input integer n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task chk(input [15:0] got, input [15:0] exp);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      n_errors = n_errors + 1;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Five cycles a write keep parameter checks apart; content stays put until the next write
  task wr(input [2:0] idx, input [15:0] d);
    wr_index = idx;
    wr_data = d;
    wr_strobe = 1;
    cyc(1);
    wr_strobe = 0;
    cyc(4);
  endtask
  task rd(input [2:0] idx, input [15:0] exp);
    rd_index = idx;
    cyc(1);
    chk(rd_data_r, exp);
  endtask
  task key;
    panel_program_key = 1;
    cyc(5);
    panel_program_key = 0;
    cyc(5);
  endtask
  task results;
    $display("errors %0d, comparisons %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #200000;
    n_errors = n_errors + 1;
    results;
  end
  initial begin
    n_errors = 0;
    tests_run = 0;
    rst = 1;
    {wr_strobe, wr_index, wr_data, rd_index, board_defective, panel_program_key} = 0;
    {drive_state_hi, drive_fault_code, motor_speed} = {8'h12, 8'h05, 16'h0a5a};
    {digital_inputs, torque_current, motor_current} = {8'hc3, 16'h0123, 16'h0456};
    {drive_enabled, link_up, board_present, board_standard} = 5'h1d;
    {fieldbus_standard_select, link_loss_behaviour} = {4'h1, 3'h3};
    {ctl_src_fieldbus, out_src_fieldbus} = {5'h01, 5'h0f};
    {max_speed_ref, sync_speed_rpm} = {16'h2800, 12'h708};
    cyc(2);
    rst = 0;
    cyc(4);
    rd(3'h1, 16'h0a5a);
    rd(3'h0, 16'h1205);
    rd(3'h2, 16'h00c3);
    rd(3'h4, 16'h0123);
    rd(3'h5, 16'h0456);
    wr(3'h1, 16'h0b8e);
    chk(speed_ref_rpm_r, 16'h028a);
    wr(3'h1, 16'h2000);
    chk(speed_ref_r, 16'h2000);
    wr(3'h1, 16'h3000);
    chk(speed_ref_r, 16'h2800);
    for (k = 0; k < 4; k = k + 1) begin
      wr(3'h2, 16'he0e0 | (16'h0101 << k));
      chk(outs, (16'h0002 << k) - 16'h0001);
    end
    wr(3'h2, 16'h0f00);
    chk(outs, 16'h0000);
    wr(3'h2, 16'h1010);
    chk({outs, flt}, 16'h0001);
    wr(3'h4, 16'h03e7);
    chk(flt, 16'h0001);
    wr(3'h0, 16'h0101);
    chk({cmd_state_r, flt}, 16'h0010);
    wr(3'h0, 16'h0002);
    chk(cmd_state_r, 16'h0001);
    wr(3'h0, 16'h0202);
    chk({cmd_state_r, flt}, 16'h0011);
    wr(3'h0, 16'h0100);
    chk({cmd_state_r, flt}, 16'h0000);
    wr_index = 3'h0;
    wr_data = 16'ha080;
    wr_strobe = 1;
    cyc(1);
    chk({fault_reset_r, save_enable_r}, 16'h0003);
    wr_strobe = 0;
    cyc(4);
    wr(3'h0, 16'h2020);
    chk({fault_reset_r, save_enable_r}, 16'h0000);
    wr(3'h3, 16'h0064);
    rd(3'h3, 16'h0032);
    wr(3'h3, 16'h01f4);
    chk(flt, 16'h0004);
    wr(3'h3, 16'h0064);
    wr(3'h4, 16'h03e7);
    chk(flt, 16'h0000);
    wr(3'h5, 16'h012c);
    wr(3'h4, 16'h0064);
    rd(3'h3, 16'h012c);
    wr(3'h4, 16'h03e7);
    for (k = 0; k < 4; k = k + 1) begin
      wr(3'h4, pnum[k*16 +: 16]);
      chk(flt, pflt[k*4 +: 4]);
      rd(3'h0, {8'h12, pcode[k*8 +: 8]});
      chk(cmd_state_r, 16'h0000);
      wr(3'h4, 16'h03e7);
      chk(flt, 16'h0000);
    end
    wr(3'h4, 16'h0064);
    wr(3'h5, 16'h07d0);
    chk(flt, 16'h0002);
    rd(3'h3, 16'h012c);
    wr(3'h5, 16'h0190);
    chk(flt, 16'h0000);
    rd(3'h3, 16'h0190);
    wr(3'h4, 16'h03e7);
    link_up = 0;
    cyc(6);
    chk({fieldbus_inactive_fault_r, loss_action_r, loss_action_sel_r}, 16'h001b);
    chk(fault_code, 16'h001d);
    link_up = 1;
    key;
    chk({fieldbus_inactive_fault_r, loss_action_r}, 16'h0000);
    for (k = 0; k < 3; k = k + 1) begin
      board_present = k != 0;
      board_defective = k == 1;
      board_standard = (k == 2) ? 2'h2 : 2'h1;
      cyc(6);
      chk({board_inactive_fault_r, loss_action_r}, 16'h0003);
      {board_present, board_defective, board_standard} = 4'h9;
      cyc(2);
      key;
      chk(board_inactive_fault_r, 16'h0000);
    end
    results;
  end
endmodule // fbph_handler_tb_top

bind fbph_handler fbph_props u_props (.*);
